//--- src/fpx_pkg.sv
// fpx_pkg: opcodes, register bank sizes, flag positions for the fp unit
// assumes one clock, operations issued one per cycle by the core
package fpx_pkg;
  localparam int FPX_W = 32;
  localparam int FPX_SREGS = 32;
  localparam int FPX_SIDX_W = 5;
  localparam int FPX_DIDX_W = 4;
  localparam int FPX_RIDX_W = 4;
  localparam logic [31:0] FPX_STATUS_RST = 32'h0000_0000;
  localparam int FPX_FLAG_N = 31;
  localparam int FPX_FLAG_Z = 30;
  localparam int FPX_FLAG_C = 29;
  localparam int FPX_FLAG_V = 28;
  localparam int FPX_SIGN = 31;
  localparam logic [3:0] FPX_RIDX_SP = 4'hD;
  localparam logic [3:0] FPX_RIDX_PC = 4'hF;
  localparam logic [3:0] FPX_RIDX_MAX = 4'hE;

  typedef enum logic [4:0] {
    FPX_NOP, FPX_LOAD, FPX_MLA, FPX_MLS, FPX_MOV_IMM, FPX_MOV_S, FPX_MOV_D,
    FPX_D_TO_R, FPX_R_TO_D, FPX_S_TO_R, FPX_R_TO_S, FPX_SS_TO_RR,
    FPX_RR_TO_SS, FPX_STAT_RD, FPX_STAT_RD_FLAGS, FPX_STAT_WR, FPX_MUL,
    FPX_NEG, FPX_NMLA, FPX_NMLS, FPX_NMUL
  } fpx_op_t;

  typedef enum logic [1:0] {
    FPX_IDLE, FPX_LOAD_WAIT
  } fpx_state_t;
endpackage

//--- src/fpx_fpmath.sv
// fpx_fpmath: combinational single-precision multiply and add
// assumes normal operands; denormals flush to zero, truncating rounding
`timescale 1ns/10ps
module fpx_fpmath (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic [31:0] c,
  input wire logic use_add,
  output logic [31:0] result
);
  logic [47:0] mprod;
  logic [8:0] pexp;
  logic [31:0] prod;
  logic [31:0] big;
  logic [31:0] sml;
  logic [7:0] ediff;
  logic [24:0] mb;
  logic [24:0] ms;
  logic [24:0] msum;
  logic [31:0] sum;
  logic [7:0] sexp;
  logic [4:0] lz;

  assign mprod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
  assign pexp = {1'b0, a[30:23]} + {1'b0, b[30:23]} - 9'd127
    + {8'h00, mprod[47]};
  always_comb begin
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || pexp[8]) begin
      prod = {a[31] ^ b[31], 31'h0};
    end else begin
      prod = {a[31] ^ b[31], pexp[7:0],
        mprod[47] ? mprod[46:24] : mprod[45:23]};
    end
  end
  assign big = (prod[30:0] >= c[30:0]) ? prod : c;
  assign sml = (prod[30:0] >= c[30:0]) ? c : prod;
  assign ediff = big[30:23] - sml[30:23];
  assign mb = {2'b01, big[22:0]};
  assign ms = (sml[30:23] == 8'h00 || ediff > 8'd24) ? 25'h0
    : ({2'b01, sml[22:0]} >> ediff);
  assign msum = (big[31] == sml[31]) ? mb + ms : mb - ms;
  // leading zeros of the sum below the carry bit
  always_comb begin
    lz = 5'h00;
    for (int k = 0; k < 24; k++) begin
      if (msum[k]) begin
        lz = 5'(23 - k);
      end
    end
  end
  always_comb begin
    sexp = big[30:23];
    sum = 32'h0;
    if (big[30:23] == 8'h00 || msum == 25'h0) begin
      sum = 32'h0;
    end else if (msum[24]) begin
      sexp = big[30:23] + 8'h01;
      sum = {big[31], sexp, msum[23:1]};
    end else if (big[30:23] > {3'h0, lz}) begin
      sum = {big[31], 8'(big[30:23] - {3'h0, lz}),
        23'(msum[22:0] << lz)};
    end else begin
      sum = 32'h0;
    end
  end
  assign result = use_add ? sum : prod;
endmodule

//--- src/fpx_unit.sv
// fpx_unit: floating-point transfer, move and multiply execution slice
// assumes core presents one operation per cycle with operands and flags
`timescale 1ns/10ps
module fpx_unit
  import fpx_pkg::*;
#(
  parameter int NREGS = FPX_SREGS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire fpx_pkg::fpx_op_t op_code,
  input wire logic cond_pass,
  input wire logic dest_omitted,
  input wire logic [4:0] single_dest_reg,
  input wire logic [4:0] single_src_first,
  input wire logic [4:0] single_src_second,
  input wire logic [3:0] double_dest_reg,
  input wire logic [3:0] double_src_reg,
  input wire logic half_index,
  input wire logic [31:0] imm_value,
  input wire logic [3:0] integer_xfer_reg,
  input wire logic [3:0] integer_xfer_reg_second,
  input wire logic [31:0] integer_xfer_data,
  input wire logic [31:0] integer_xfer_data_second,
  input wire logic [31:0] integer_base_value,
  input wire logic [31:0] load_offset,
  input wire logic load_is_double,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  input wire logic [3:0] core_condition_flags,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_double,
  output logic core_wr_en,
  output logic [3:0] core_wr_reg,
  output logic [31:0] core_wr_data,
  output logic core_wr_en_second,
  output logic [3:0] core_wr_reg_second,
  output logic [31:0] core_wr_data_second,
  output logic flags_wr_en,
  output logic [3:0] flags_wr_value,
  output logic [31:0] fp_status_control_reg,
  output logic busy,
  output logic op_error
);
  import fpx_pkg::*;

  logic [31:0] bank_q [NREGS];
  fpx_state_t state_q;
  logic [4:0] ld_sreg_q;
  logic [3:0] ld_dreg_q;
  logic ld_dbl_q;
  logic [31:0] status_q;

  // sign flip shared by negate and the negated-accumulator forms NMLA and NMLS
  function automatic logic [31:0] flip_sign(input logic [31:0] v);
    flip_sign = {~v[FPX_SIGN], v[FPX_SIGN - 1:0]};
  endfunction

  // operation accepted only when the condition holds
  wire fire = op_valid && cond_pass && state_q == FPX_IDLE;
  wire [4:0] dst = (dest_omitted &&
    (op_code == FPX_MUL || op_code == FPX_NMUL))
    ? single_src_first : single_dest_reg;
  wire [31:0] sn = bank_q[single_src_first];
  wire [31:0] sm = bank_q[single_src_second];
  wire [31:0] sd = bank_q[dst];
  wire [4:0] s_next = single_src_second + 5'h01;
  wire [4:0] dd_lo = {double_dest_reg, 1'b0};
  wire [4:0] dm_lo = {double_src_reg, 1'b0};
  wire [4:0] dn_w = {double_src_reg, half_index};
  wire [4:0] dd_w = {double_dest_reg, half_index};
  wire bad_core = (integer_xfer_reg == FPX_RIDX_SP)
    || (integer_xfer_reg == FPX_RIDX_PC);
  wire is_xfer = op_code inside {FPX_D_TO_R, FPX_R_TO_D, FPX_S_TO_R,
    FPX_R_TO_S, FPX_SS_TO_RR, FPX_RR_TO_SS, FPX_STAT_RD, FPX_STAT_WR};
  wire xfer_bad = is_xfer && bad_core;
  // load accepted, load answered
  wire take_load = fire && op_code == FPX_LOAD;
  wire load_done = state_q == FPX_LOAD_WAIT && mem_ack;
  // base plus offset, wrapping in 32 bits
  wire [31:0] load_addr = integer_base_value + load_offset;
  // nzcv bits picked from the status word
  wire [3:0] status_nzcv = {status_q[FPX_FLAG_N], status_q[FPX_FLAG_Z],
    status_q[FPX_FLAG_C], status_q[FPX_FLAG_V]};
  // status read may only land in r0-r14
  wire stat_rd_ok = integer_xfer_reg <= FPX_RIDX_MAX;

  // accumulator term: sign chosen per operation
  logic [31:0] acc_in;
  logic prod_neg;
  logic use_add;
  always_comb begin
    acc_in = sd;
    prod_neg = 1'b0;
    use_add = 1'b0;
    case (op_code)
      FPX_MLA: begin
        use_add = 1'b1;
      end
      FPX_MLS: begin
        use_add = 1'b1;
        prod_neg = 1'b1;
      end
      FPX_NMLA: begin
        use_add = 1'b1;
        prod_neg = 1'b1;
        acc_in = flip_sign(sd);
      end
      FPX_NMLS: begin
        use_add = 1'b1;
        acc_in = flip_sign(sd);
      end
      FPX_NMUL: begin
        prod_neg = 1'b1;
      end
      default: begin
      end
    endcase
  end

  wire [31:0] sn_signed = {sn[FPX_SIGN] ^ prod_neg, sn[30:0]};
  wire [31:0] arith_res;

  fpx_fpmath u_math (
    .a(sn_signed),
    .b(sm),
    .c(acc_in),
    .use_add(use_add),
    .result(arith_res)
  );

  // state machine for the memory load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= FPX_IDLE;
      ld_sreg_q <= 5'h00;
      ld_dreg_q <= 4'h0;
      ld_dbl_q <= 1'b0;
      mem_req <= 1'b0;
      mem_addr <= 32'h0;
      mem_double <= 1'b0;
      busy <= 1'b0;
    end else begin
      case (state_q)
        FPX_IDLE: begin
          if (take_load) begin
            state_q <= FPX_LOAD_WAIT;
            mem_req <= 1'b1;
            mem_addr <= load_addr;
            mem_double <= load_is_double;
            ld_dbl_q <= load_is_double;
            ld_sreg_q <= single_dest_reg;
            ld_dreg_q <= double_dest_reg;
            busy <= 1'b1;
          end
        end
        FPX_LOAD_WAIT: begin
          if (mem_ack) begin
            state_q <= FPX_IDLE;
            mem_req <= 1'b0;
            busy <= 1'b0;
          end
        end
        default: begin
          state_q <= FPX_IDLE;
        end
      endcase
    end
  end

  // register bank writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREGS; i++) begin
        bank_q[i] <= 32'h0;
      end
    end else if (load_done) begin
      if (ld_dbl_q) begin
        bank_q[{ld_dreg_q, 1'b0}] <= mem_rdata[31:0];
        bank_q[{ld_dreg_q, 1'b1}] <= mem_rdata[63:32];
      end else begin
        bank_q[ld_sreg_q] <= mem_rdata[31:0];
      end
    end else if (fire && !xfer_bad) begin
      case (op_code)
        // arithmetic forms all land on the chosen destination
        FPX_MLA, FPX_MLS, FPX_NMLA, FPX_NMLS, FPX_MUL, FPX_NMUL: begin
          bank_q[dst] <= arith_res;
        end
        FPX_NEG: begin
          bank_q[single_dest_reg] <= flip_sign(sm);
        end
        FPX_MOV_IMM: begin
          bank_q[single_dest_reg] <= imm_value;
        end
        FPX_MOV_S: begin
          bank_q[single_dest_reg] <= sm;
        end
        // double move copies both halves
        FPX_MOV_D: begin
          bank_q[dd_lo] <= bank_q[dm_lo];
          bank_q[dd_lo + 5'h01] <= bank_q[dm_lo + 5'h01];
        end
        FPX_R_TO_D: begin
          bank_q[dd_w] <= integer_xfer_data;
        end
        FPX_R_TO_S: begin
          bank_q[single_src_first] <= integer_xfer_data;
        end
        // second register always follows the first
        FPX_RR_TO_SS: begin
          bank_q[single_src_second] <= integer_xfer_data;
          bank_q[s_next] <= integer_xfer_data_second;
        end
        default: begin
        end
      endcase
    end
  end

  // status register and core-side writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= FPX_STATUS_RST;
      fp_status_control_reg <= FPX_STATUS_RST;
      core_wr_en <= 1'b0;
      core_wr_reg <= 4'h0;
      core_wr_data <= 32'h0;
      core_wr_en_second <= 1'b0;
      core_wr_reg_second <= 4'h0;
      core_wr_data_second <= 32'h0;
      flags_wr_en <= 1'b0;
      flags_wr_value <= 4'h0;
      op_error <= 1'b0;
    end else begin
      // core-side strobes are one-cycle pulses
      core_wr_en <= 1'b0;
      core_wr_en_second <= 1'b0;
      flags_wr_en <= 1'b0;
      flags_wr_value <= core_condition_flags;
      op_error <= fire && xfer_bad;
      fp_status_control_reg <= status_q;
      if (fire && !xfer_bad) begin
        core_wr_reg <= integer_xfer_reg;
        core_wr_reg_second <= integer_xfer_reg_second;
        case (op_code)
          FPX_D_TO_R: begin
            core_wr_en <= 1'b1;
            core_wr_data <= bank_q[dn_w];
          end
          FPX_S_TO_R: begin
            core_wr_en <= 1'b1;
            core_wr_data <= sn;
          end
          FPX_SS_TO_RR: begin
            core_wr_en <= 1'b1;
            core_wr_data <= sm;
            core_wr_en_second <= 1'b1;
            core_wr_data_second <= bank_q[s_next];
          end
          FPX_STAT_RD: begin
            core_wr_en <= stat_rd_ok;
            core_wr_data <= status_q;
          end
          FPX_STAT_RD_FLAGS: begin
            flags_wr_en <= 1'b1;
            flags_wr_value <= status_nzcv;
          end
          FPX_STAT_WR: begin
            status_q <= integer_xfer_data;
            fp_status_control_reg <= integer_xfer_data;
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule

//--- tb/fpx_unit_checker.sv
// fpx_unit_checker: timing relations on the fp unit ports
// assumes results are registered on the edge that takes the op
`timescale 1ns/10ps
module fpx_unit_checker
  import fpx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire fpx_pkg::fpx_op_t op_code,
  input wire logic cond_pass,
  input wire logic busy,
  input wire logic [3:0] integer_xfer_reg,
  input wire logic [31:0] integer_xfer_data,
  input wire logic [31:0] integer_base_value,
  input wire logic [31:0] load_offset,
  input wire logic mem_ack,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic core_wr_en,
  input wire logic [31:0] core_wr_data,
  input wire logic flags_wr_en,
  input wire logic [3:0] flags_wr_value,
  input wire logic [31:0] fp_status_control_reg,
  input wire logic op_error
);
  import fpx_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic go;
  logic bad;
  assign go = op_valid && cond_pass && !busy;
  assign bad = integer_xfer_reg == FPX_RIDX_SP
    || integer_xfer_reg == FPX_RIDX_PC;
  sequence take(fpx_op_t c); go && op_code == c; endsequence
  sequence load_wait; mem_req && !mem_ack; endsequence
  flag_source_a: assert property (flags_wr_en |->
    $past(go && op_code == FPX_STAT_RD_FLAGS)) else $error("flag source");
  flag_value_a: assert property (flags_wr_en |->
    flags_wr_value == $past(fp_status_control_reg[31:28])) else $error("nzcv");
  stat_write_a: assert property (take(FPX_STAT_WR) ##0 !bad |=>
    fp_status_control_reg == $past(integer_xfer_data)) else $error("swr");
  stat_read_a: assert property (take(FPX_STAT_RD) ##0 !bad |=>
    core_wr_en && core_wr_data == $past(fp_status_control_reg))
    else $error("srd");
  cond_fail_a: assert property (op_valid && !cond_pass && !busy |=>
    !core_wr_en && !flags_wr_en && !mem_req) else $error("cond");
  sp_refuse_a: assert property (take(FPX_S_TO_R) ##0 bad |=>
    op_error && !core_wr_en) else $error("refuse");
  load_addr_a: assert property (take(FPX_LOAD) |=>
    mem_req && mem_addr == $past(integer_base_value + load_offset))
    else $error("load addr");
  load_hold_a: assert property (load_wait |=>
    busy && mem_req && $stable(mem_addr)) else $error("load hold");
endmodule

bind fpx_unit fpx_unit_checker u_chk (.*);

//--- tb/fpx_mem_model.sv
// fpx_mem_model: memory answering load requests of the fp unit
// assumes one request at a time; answers on the lat+1-th edge that sees the request
`timescale 1ns/10ps
module fpx_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_double,
  output logic mem_ack,
  output logic [63:0] mem_rdata
);
  logic [3:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      mem_ack <= 1'h0;
      mem_rdata <= 64'h0;
    end else if (mem_req && !mem_ack && cnt_q >= lat) begin
      mem_ack <= 1'h1;
      mem_rdata <= {~mem_addr, mem_addr ^ 32'h5A5A_0000};
    end else begin
      cnt_q <= mem_req && !mem_ack ? cnt_q + 4'h1 : 4'h0;
      mem_ack <= 1'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

//--- tb/tb_top.sv
// tb_top: directed scenarios for the fp unit with a memory model
// assumes each result shows within three edges of an accepted op
`timescale 1ns/10ps
module tb_top;
  import fpx_pkg::*;
  logic clk = 1'h0, rst = 1'h1, op_valid = 1'h0, cond_pass = 1'h1;
  logic dest_omitted = 1'h0, half_index = 1'h0, load_is_double = 1'h1;
  logic [4:0] single_dest_reg, single_src_first, single_src_second;
  logic [3:0] double_dest_reg, double_src_reg, lat = 4'h0;
  logic [3:0] integer_xfer_reg = 4'h2, integer_xfer_reg_second = 4'h6;
  logic [3:0] core_condition_flags = 4'hA;
  logic [31:0] imm_value, integer_xfer_data, load_offset = 32'h10;
  logic [31:0] integer_xfer_data_second = 32'h1234_5678;
  logic [31:0] integer_base_value = 32'h0;
  fpx_op_t op_code = FPX_NOP;
  wire mem_ack, mem_req, mem_double, core_wr_en, core_wr_en_second;
  wire flags_wr_en, busy, op_error;
  wire [63:0] mem_rdata;
  wire [31:0] mem_addr, core_wr_data, core_wr_data_second;
  wire [31:0] fp_status_control_reg;
  wire [3:0] core_wr_reg, core_wr_reg_second, flags_wr_value;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  fpx_unit DUT (.*);
  fpx_mem_model mem (.*);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // x feeds both the core data and the immediate
  task automatic op(input fpx_op_t c, input logic [4:0] d, input logic [4:0] n,
      input logic [4:0] m, input logic [31:0] x, input logic [3:0] dd);
    @(posedge clk);
    op_valid <= 1'h1;
    op_code <= c;
    single_dest_reg <= d;
    single_src_first <= n;
    single_src_second <= m;
    integer_xfer_data <= x;
    imm_value <= x;
    double_dest_reg <= dd;
    double_src_reg <= c == FPX_MOV_D ? 4'h1 : dd;
    @(posedge clk);
    op_valid <= 1'h0;
    #1;
    for (int k = 0; k < 3 && !(core_wr_en === 1'h1 || op_error === 1'h1
        || flags_wr_en === 1'h1 || busy === 1'h1); k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wr(input logic [4:0] s, input logic [31:0] v);
    op(FPX_R_TO_S, s, s, s, v, 4'h0);
  endtask
  task automatic rd(input logic [4:0] s, input logic [31:0] e);
    op(FPX_S_TO_R, s, s, s, 32'h0, 4'h0);
    chk(core_wr_data, e);
  endtask
  task automatic t_arith();
    fpx_op_t ops[7] = '{FPX_MLA, FPX_MLS, FPX_NMLA, FPX_NMLS, FPX_MUL,
        FPX_NMUL, FPX_NEG};
    logic [31:0] exp[7] = '{32'h40E0_0000, 32'hC0A0_0000, 32'hC0E0_0000,
        32'h40A0_0000, 32'h40C0_0000, 32'hC0C0_0000, 32'hC040_0000};
    for (int i = 0; i < 7; i++) begin
      wr(3, 32'h4000_0000);
      wr(4, 32'h4040_0000);
      wr(5, 32'h3F80_0000);
      op(ops[i], 5'h5, 5'h3, 5'h4, 32'h0, 4'h0);
      rd(5, exp[i]);
    end
    @(posedge clk);
    dest_omitted <= 1'h1;
    op(FPX_NMUL, 5'h9, 5'h3, 5'h4, 32'h0, 4'h0);
    @(posedge clk);
    dest_omitted <= 1'h0;
    rd(3, 32'hC0C0_0000);
  endtask
  task automatic t_move();
    op(FPX_MOV_IMM, 5'h7, 5'h7, 5'h7, 32'h3FC0_0000, 4'h0);
    @(posedge clk);
    cond_pass <= 1'h0;
    op(FPX_MOV_IMM, 5'h7, 5'h7, 5'h7, 32'h4110_0000, 4'h0);
    @(posedge clk);
    cond_pass <= 1'h1;
    rd(7, 32'h3FC0_0000);
    op(FPX_MOV_S, 5'h8, 5'h7, 5'h7, 32'h0, 4'h0);
    rd(8, 32'h3FC0_0000);
    wr(2, 32'h1111_2222);
    wr(3, 32'h3333_4444);
    op(FPX_MOV_D, 5'h0, 5'h0, 5'h0, 32'h0, 4'h2);
    rd(5, 32'h3333_4444);
    op(FPX_D_TO_R, 5'h0, 5'h0, 5'h0, 32'h0, 4'h1);
    chk(core_wr_data, 32'h1111_2222);
    @(posedge clk);
    half_index <= 1'h1;
    op(FPX_R_TO_D, 5'h0, 5'h0, 5'h0, 32'h5555_6666, 4'h1);
    op(FPX_D_TO_R, 5'h0, 5'h0, 5'h0, 32'h0, 4'h1);
    chk(core_wr_data, 32'h5555_6666);
    @(posedge clk);
    half_index <= 1'h0;
    rd(2, 32'h1111_2222);
    op(FPX_RR_TO_SS, 5'hA, 5'hA, 5'hA, 32'h7777_8888, 4'h0);
    rd(5'hB, 32'h1234_5678);
    op(FPX_SS_TO_RR, 5'hA, 5'hA, 5'hA, 32'h0, 4'h0);
    chk(core_wr_data, 32'h7777_8888);
    chk({28'h0, core_wr_reg_second}, 32'h6);
    chk({31'h0, core_wr_en_second}, 32'h1);
    chk(core_wr_data_second, 32'h1234_5678);
  endtask
  task automatic t_status();
    chk(fp_status_control_reg, FPX_STATUS_RST);
    op(FPX_STAT_WR, 5'h0, 5'h0, 5'h0, 32'h9000_00F0, 4'h0);
    chk(fp_status_control_reg, 32'h9000_00F0);
    op(FPX_STAT_RD_FLAGS, 5'h0, 5'h0, 5'h0, 32'h0, 4'h0);
    chk({31'h0, flags_wr_en}, 32'h1);
    chk({28'h0, flags_wr_value}, 32'h9);
    @(posedge clk);
    integer_xfer_reg <= 4'hE;
    op(FPX_STAT_RD, 5'h0, 5'h0, 5'h0, 32'h0, 4'h0);
    chk(core_wr_data, 32'h9000_00F0);
    chk({28'h0, core_wr_reg}, 32'hE);
    chk({31'h0, flags_wr_en}, 32'h0);
    @(posedge clk);
    integer_xfer_reg <= FPX_RIDX_SP;
    op(FPX_S_TO_R, 5'h1, 5'h1, 5'h1, 32'h0, 4'h0);
    chk({31'h0, op_error}, 32'h1);
    chk({31'h0, core_wr_en}, 32'h0);
    @(posedge clk);
    integer_xfer_reg <= 4'h2;
  endtask
  task automatic t_load();
    logic [31:0] a;
    for (int i = 0; i < 2; i++) begin
      a = 32'h2000_0110 + 32'(i * 8);
      @(posedge clk);
      lat <= i == 0 ? 4'h0 : 4'h5;
      integer_base_value <= a - 32'h10;
      op(FPX_LOAD, 5'h0, 5'h0, 5'h0, 32'h0, 4'h3);
      chk(mem_addr, a);
      chk({31'h0, mem_double}, 32'h1);
      for (int k = 0; k < 20 && busy !== 1'h0; k++) begin
        @(posedge clk);
        #1;
      end
      rd(6, a ^ 32'h5A5A_0000);
      rd(7, ~a);
    end
    @(posedge clk);
    load_is_double <= 1'h0;
    op(FPX_LOAD, 5'h9, 5'h0, 5'h0, 32'h0, 4'h3);
    chk({31'h0, mem_double}, 32'h0);
    for (int k = 0; k < 20 && busy !== 1'h0; k++) begin
      @(posedge clk);
      #1;
    end
    rd(9, a ^ 32'h5A5A_0000);
    rd(7, ~a);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_status();
    t_arith();
    t_move();
    t_load();
    print_verdict();
  end
endmodule
